// File: sam_cfg.svh
`ifndef SAM_CFG_SVH
`define SAM_CFG_SVH
`define SAM_PAGES 6
`define SAM_BANDS 6
`define SAM_OFF_XWARN 8'h24
`define SAM_OFF_YWARN 8'h26
`define SAM_OFF_XCRIT 8'h28
`define SAM_OFF_YCRIT 8'h2A
`define SAM_OFF_SLVL 8'h2E
`define SAM_OFF_CTRL 8'h30
`define SAM_OFF_DIAG 8'h34
`define SAM_OFF_CMD 8'h36
`define SAM_OFF_XSTAT 8'h38
`define SAM_OFF_YSTAT 8'h3A
`define SAM_OFF_XPEAK 8'h3C
`define SAM_OFF_YPEAK 8'h3E
`define SAM_OFF_XBIN 8'h44
`define SAM_OFF_YBIN 8'h46
`define SAM_LVL_RST 16'h0000
`define SAM_CTRL_RST 16'h0080
`define SAM_CTRL_MASK 16'h0FFB
`define SAM_CTRL_SEN 3
`define SAM_CTRL_SSEL 4
`define SAM_CTRL_SPOL 5
`define SAM_CTRL_DOEN 6
`define SAM_CTRL_LATCH 7
`define SAM_CTRL_DLY_LSB 8
`define SAM_CTRL_DLY_MSB 11
`define SAM_CMD_CLRST 4
`define SAM_CMD_CLRALM 9
`define SAM_CMD_SAVE 12
`define SAM_DIAG_S 2
`define SAM_CNT_MAX 4'hF
`define SAM_WARN_BITS 12'h555
`define SAM_PIN_ALARM 6'h01
`endif

// File: sam_host.sv
`timescale 1ns/1ps
// ----------
// host side of the register port
// ----------
module sam_host (
	// clock
	input wire logic CLK,
	// register port
	output logic REG_WR,
	output logic REG_RD,
	output logic [2:0] REG_PAGE,
	output logic [7:0] REG_ADDR,
	output logic [7:0] REG_WDATA
);
	initial begin
		REG_WR = 1'b0;
		REG_RD = 1'b0;
		REG_PAGE = 3'h1;
		REG_ADDR = 8'h00;
		REG_WDATA = 8'h00;
	end
	// released data shows the inverse, so a stale byte never looks valid
	task automatic wb(input logic [2:0] pg, input logic [7:0] a, input logic [7:0] d);
		@(posedge CLK);
		REG_WR <= 1'b1;
		REG_PAGE <= pg;
		REG_ADDR <= a;
		REG_WDATA <= d;
		@(posedge CLK);
		REG_WR <= 1'b0;
		REG_WDATA <= ~d;
	endtask
	// low byte first, each byte lands alone
	task automatic wr(input logic [2:0] pg, input logic [7:0] a, input logic [15:0] d);
		wb(pg, {a[7:1], 1'b0}, d[7:0]);
		wb(pg, {a[7:1], 1'b1}, d[15:8]);
	endtask
	task automatic rd(input logic [2:0] pg, input logic [7:0] a);
		@(posedge CLK);
		REG_RD <= 1'b1;
		REG_PAGE <= pg;
		REG_ADDR <= a;
		@(posedge CLK);
		REG_RD <= 1'b0;
	endtask
	task automatic clr(input logic [2:0] pg);
		wb(pg, 8'h37, 8'h02);
	endtask
	task automatic save(input logic [2:0] pg);
		wb(pg, 8'h37, 8'h10);
	endtask
endmodule

// File: sam_monitor.sv
`timescale 1ns/1ps
`include "sam_cfg.svh"
module sam_monitor #(
	parameter logic [5:0] PIN_ALARM = `SAM_PIN_ALARM
) (
	// clock and reset
	input wire logic CLK,
	input wire logic SRST,
	// register port
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [2:0] REG_PAGE,
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	output logic [15:0] REG_RDATA,
	// spectral record stream
	input wire logic BIN_VALID,
	input wire logic BIN_AXIS,
	input wire logic [7:0] BIN_INDEX,
	input wire logic [15:0] BIN_MAG,
	input wire logic REC_DONE,
	input wire logic [2:0] REC_PAGE,
	input wire logic [47:0] BAND_LOW,
	input wire logic [47:0] BAND_HIGH,
	input wire logic [15:0] SYS_TEMP,
	input wire logic [15:0] SYS_SUPPLY,
	// pin function select
	input wire logic [5:0] PIN_FUNC,
	// alarm pins and save request
	output logic DIG_OUT1,
	output logic DIG_OUT2,
	output logic SAVE_STROBE,
	output logic [2:0] SAVE_PAGE,
	// record header
	output logic HDR_VALID,
	output logic [2:0] HDR_PAGE,
	output logic [15:0] HDR_DIAG,
	output logic [15:0] HDR_XSTAT,
	output logic [15:0] HDR_YSTAT,
	output logic [15:0] HDR_XPEAK,
	output logic [15:0] HDR_YPEAK,
	output logic [7:0] HDR_XBIN,
	output logic [7:0] HDR_YBIN
);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic pg_ok(input logic [2:0] pg);
		return (pg != 3'h0) && (pg != 3'h7);
	endfunction

	function automatic logic [15:0] put_byte(input logic [15:0] w, input logic hi,
		input logic [7:0] b);
		return hi ? {b, w[7:0]} : {w[15:8], b};
	endfunction

	// lowest band wins a tie
	function automatic logic [2:0] worst_band(input logic [11:0] f);
		logic [2:0] c;
		logic [2:0] w;
		c = 3'h0;
		w = 3'h0;
		for (int i = 5; i >= 0; i--) begin
			if (f[2*i+1]) begin
				c = 3'(i + 1);
			end
			if (f[2*i]) begin
				w = 3'(i + 1);
			end
		end
		return (c != 3'h0) ? c : w;
	endfunction

	sam_pkg::sam_state_t r_reg;
	sam_pkg::sam_state_t r_next;
	logic [2:0] wp;
	logic [2:0] rp;
	logic [7:0] wa;

	assign wp = REG_PAGE - 3'h1;
	assign rp = REC_PAGE - 3'h1;
	assign wa = {REG_ADDR[7:1], 1'b0};

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		logic [15:0] cmd;
		logic [15:0] sv;
		logic [15:0] nd;
		logic [11:0] fl;
		logic [7:0] lo;
		logic [7:0] hi;
		logic [3:0] dly;
		logic hit;
		logic sa;
		logic en;
		cmd = 16'h0000;
		sv = 16'h0000;
		nd = 16'h0000;
		fl = 12'h000;
		lo = 8'h00;
		hi = 8'h00;
		dly = 4'h0;
		hit = 1'b0;
		sa = 1'b0;
		en = 1'b0;
		r_next = r_reg;
		r_next.save = 1'b0;
		r_next.hdr_v = 1'b0;

		// register reads, answered one edge later
		if (REG_RD) begin
			r_next.rdata = 16'h0000;
			if (pg_ok(REG_PAGE)) begin
				case (wa)
					`SAM_OFF_XWARN: r_next.rdata = r_reg.warn[wp][0];
					`SAM_OFF_YWARN: r_next.rdata = r_reg.warn[wp][1];
					`SAM_OFF_XCRIT: r_next.rdata = r_reg.crit[wp][0];
					`SAM_OFF_YCRIT: r_next.rdata = r_reg.crit[wp][1];
					`SAM_OFF_SLVL: r_next.rdata = r_reg.slvl[wp];
					`SAM_OFF_CTRL: r_next.rdata = r_reg.ctrl[wp];
					`SAM_OFF_DIAG: r_next.rdata = r_reg.diag[wp];
					`SAM_OFF_XSTAT: r_next.rdata = r_reg.stat[wp][0];
					`SAM_OFF_YSTAT: r_next.rdata = r_reg.stat[wp][1];
					`SAM_OFF_XPEAK: r_next.rdata = r_reg.peak[wp][0];
					`SAM_OFF_YPEAK: r_next.rdata = r_reg.peak[wp][1];
					`SAM_OFF_XBIN: r_next.rdata = {8'h00, r_reg.pbin[wp][0]};
					`SAM_OFF_YBIN: r_next.rdata = {8'h00, r_reg.pbin[wp][1]};
					default: r_next.rdata = 16'h0000;
				endcase
			end
		end

		// byte writes; odd address is the high byte
		if (REG_WR && pg_ok(REG_PAGE)) begin
			case (wa)
				`SAM_OFF_XWARN: begin
					r_next.warn[wp][0] = put_byte(r_reg.warn[wp][0], REG_ADDR[0], REG_WDATA);
					r_next.dirty[wp] = 1'b1;
				end
				`SAM_OFF_YWARN: begin
					r_next.warn[wp][1] = put_byte(r_reg.warn[wp][1], REG_ADDR[0], REG_WDATA);
					r_next.dirty[wp] = 1'b1;
				end
				`SAM_OFF_XCRIT: begin
					r_next.crit[wp][0] = put_byte(r_reg.crit[wp][0], REG_ADDR[0], REG_WDATA);
					r_next.dirty[wp] = 1'b1;
				end
				`SAM_OFF_YCRIT: begin
					r_next.crit[wp][1] = put_byte(r_reg.crit[wp][1], REG_ADDR[0], REG_WDATA);
					r_next.dirty[wp] = 1'b1;
				end
				`SAM_OFF_SLVL: begin
					r_next.slvl[wp] = put_byte(r_reg.slvl[wp], REG_ADDR[0], REG_WDATA);
					r_next.dirty[wp] = 1'b1;
				end
				`SAM_OFF_CTRL: begin
					r_next.ctrl[wp] = put_byte(r_reg.ctrl[wp], REG_ADDR[0], REG_WDATA)
						& `SAM_CTRL_MASK;
				end
				`SAM_OFF_CMD: begin
					cmd = put_byte(16'h0000, REG_ADDR[0], REG_WDATA);
					if (cmd[`SAM_CMD_CLRALM]) begin
						r_next.warn[wp] = '0;
						r_next.crit[wp] = '0;
						r_next.slvl[wp] = `SAM_LVL_RST;
						r_next.dirty[wp] = 1'b0;
					end
					if (cmd[`SAM_CMD_SAVE] && !r_reg.dirty[wp]) begin
						r_next.save = 1'b1;
						r_next.save_pg = REG_PAGE;
					end
					if (cmd[`SAM_CMD_CLRST]) begin
						r_next.diag[wp] = 16'h0000;
					end
				end
				default: begin
				end
			endcase
		end

		// bins of the record in flight; bounds are those of the current rate
		if (BIN_VALID && pg_ok(REC_PAGE)) begin
			for (int k = 0; k < `SAM_BANDS; k++) begin
				lo = BAND_LOW[8*k +: 8];
				hi = BAND_HIGH[8*k +: 8];
				if (BIN_INDEX >= lo && BIN_INDEX <= hi) begin
					if (BIN_MAG > r_reg.warn[rp][BIN_AXIS]) begin
						r_next.acc[BIN_AXIS][2*k] = 1'b1;
						hit = 1'b1;
					end
					if (BIN_MAG > r_reg.crit[rp][BIN_AXIS]) begin
						r_next.acc[BIN_AXIS][2*k+1] = 1'b1;
					end
				end
			end
			if (hit && BIN_MAG > r_reg.amag[BIN_AXIS]) begin
				r_next.amag[BIN_AXIS] = BIN_MAG;
				r_next.abin[BIN_AXIS] = BIN_INDEX;
			end
		end

		// end of record: delay filter, status, header
		if (REC_DONE && pg_ok(REC_PAGE)) begin
			dly = r_reg.ctrl[rp][`SAM_CTRL_DLY_MSB:`SAM_CTRL_DLY_LSB];
			for (int a = 0; a < 2; a++) begin
				en = r_reg.ctrl[rp][a];
				for (int k = 0; k < 12; k++) begin
					if (r_reg.acc[a][k] && en) begin
						fl[k] = (r_reg.cnt[rp][a][k] >= dly);
						if (r_reg.cnt[rp][a][k] != `SAM_CNT_MAX) begin
							r_next.cnt[rp][a][k] = r_reg.cnt[rp][a][k] + 4'h1;
						end
					end else begin
						fl[k] = 1'b0;
						r_next.cnt[rp][a][k] = 4'h0;
					end
				end
				r_next.stat[rp][a] = {fl, 1'b0, worst_band(fl)};
				r_next.peak[rp][a] = (|fl) ? r_reg.amag[a] : 16'h0000;
				r_next.pbin[rp][a] = (|fl) ? r_reg.abin[a] : 8'h00;
				nd[a] = |fl;
			end
			sv = r_reg.ctrl[rp][`SAM_CTRL_SSEL] ? SYS_TEMP : SYS_SUPPLY;
			if (r_reg.ctrl[rp][`SAM_CTRL_SPOL]) begin
				sa = sv < r_reg.slvl[rp];
			end else begin
				sa = sv > r_reg.slvl[rp];
			end
			nd[`SAM_DIAG_S] = sa && r_reg.ctrl[rp][`SAM_CTRL_SEN];
			// new flags win over a clear-status in the same cycle
			if (r_reg.ctrl[rp][`SAM_CTRL_LATCH]) begin
				r_next.diag[rp] = r_next.diag[rp] | nd;
			end else begin
				r_next.diag[rp] = nd;
			end
			r_next.acc = '0;
			r_next.amag = '0;
			r_next.abin = '0;
			r_next.hdr_v = 1'b1;
			r_next.hdr_pg = rp;
		end

		// alarm pins: any page that owns them and has an alarm
		r_next.do1 = 1'b0;
		r_next.do2 = 1'b0;
		for (int p = 0; p < `SAM_PAGES; p++) begin
			if (r_next.ctrl[p][`SAM_CTRL_DOEN] && PIN_FUNC == PIN_ALARM) begin
				for (int a = 0; a < 2; a++) begin
					if (|(r_next.stat[p][a][15:4] & `SAM_WARN_BITS)) begin
						r_next.do1 = 1'b1;
					end
					if (|(r_next.stat[p][a][15:4] & ~`SAM_WARN_BITS)) begin
						r_next.do2 = 1'b1;
					end
				end
			end
		end
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge CLK) begin
		if (SRST) begin
			r_reg <= '0;
			for (int p = 0; p < `SAM_PAGES; p++) begin
				r_reg.ctrl[p] <= `SAM_CTRL_RST;
			end
		end else begin
			r_reg <= r_next;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign REG_RDATA = r_reg.rdata;
	assign DIG_OUT1 = r_reg.do1;
	assign DIG_OUT2 = r_reg.do2;
	assign SAVE_STROBE = r_reg.save;
	assign SAVE_PAGE = r_reg.save_pg;
	assign HDR_VALID = r_reg.hdr_v;
	assign HDR_PAGE = r_reg.hdr_pg + 3'h1;
	assign HDR_DIAG = r_reg.diag[r_reg.hdr_pg];
	assign HDR_XSTAT = r_reg.stat[r_reg.hdr_pg][0];
	assign HDR_YSTAT = r_reg.stat[r_reg.hdr_pg][1];
	assign HDR_XPEAK = r_reg.peak[r_reg.hdr_pg][0];
	assign HDR_YPEAK = r_reg.peak[r_reg.hdr_pg][1];
	assign HDR_XBIN = r_reg.pbin[r_reg.hdr_pg][0];
	assign HDR_YBIN = r_reg.pbin[r_reg.hdr_pg][1];

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (SRST);

	sequence cmd_wr_s;
		REG_WR && pg_ok(REG_PAGE) && wa == `SAM_OFF_CMD && REG_ADDR[0];
	endsequence

	sequence save_dirty_s;
		cmd_wr_s and REG_WDATA[`SAM_CMD_SAVE-8] && r_reg.dirty[wp];
	endsequence

	save_gate_a: assert property (save_dirty_s |=> !SAVE_STROBE)
		else $error("save taken after a level write");
	clear_erase_a: assert property (cmd_wr_s and REG_WDATA[`SAM_CMD_CLRALM-8]
		|=> r_reg.warn[$past(wp)] == '0 && !r_reg.dirty[$past(wp)])
		else $error("alarm clear left levels");
	level_write_a: assert property (REG_WR && pg_ok(REG_PAGE) && wa == `SAM_OFF_XWARN
		&& !REG_ADDR[0] |=> r_reg.warn[$past(wp)][0][7:0] == $past(REG_WDATA))
		else $error("warning level byte not stored");
	stat_gap_a: assert property (HDR_VALID |-> !HDR_XSTAT[3] && !HDR_YSTAT[3])
		else $error("status bit 3 set");
	worst_zero_a: assert property (HDR_VALID |->
		((HDR_XSTAT[2:0] == 3'h0) == (HDR_XSTAT[15:4] == 12'h000)))
		else $error("most critical band disagrees with flags");
	hdr_page_a: assert property (REC_DONE && pg_ok(REC_PAGE)
		|=> HDR_VALID && HDR_PAGE == $past(REC_PAGE) ##1 !HDR_VALID || $past(REC_DONE))
		else $error("header not issued for record");
	axis_off_a: assert property (REC_DONE && pg_ok(REC_PAGE) && !r_reg.ctrl[rp][0]
		|=> HDR_XSTAT[15:4] == 12'h000 && HDR_XPEAK == 16'h0000)
		else $error("disabled axis raised alarm");
	pin_func_a: assert property (PIN_FUNC != PIN_ALARM |=> !DIG_OUT1 && !DIG_OUT2)
		else $error("alarm pin driven without alarm function");
	latch_hold_a: assert property (pg_ok(REC_PAGE) && r_reg.ctrl[rp][`SAM_CTRL_LATCH]
		&& r_reg.diag[rp][`SAM_DIAG_S] && !REG_WR |=> r_reg.diag[$past(rp)][`SAM_DIAG_S])
		else $error("latched flag dropped");
endmodule

// File: sam_pkg.sv
`include "sam_cfg.svh"
package sam_pkg;
	typedef logic [`SAM_PAGES-1:0][1:0][15:0] sam_axis_words_t;
	typedef struct packed {
		sam_axis_words_t warn;
		sam_axis_words_t crit;
		logic [`SAM_PAGES-1:0][15:0] slvl;
		logic [`SAM_PAGES-1:0][15:0] ctrl;
		logic [`SAM_PAGES-1:0][15:0] diag;
		logic [`SAM_PAGES-1:0] dirty;
		sam_axis_words_t stat;
		sam_axis_words_t peak;
		logic [`SAM_PAGES-1:0][1:0][7:0] pbin;
		logic [`SAM_PAGES-1:0][1:0][11:0][3:0] cnt;
		logic [1:0][11:0] acc;
		logic [1:0][15:0] amag;
		logic [1:0][7:0] abin;
		logic [15:0] rdata;
		logic save;
		logic [2:0] save_pg;
		logic hdr_v;
		logic [2:0] hdr_pg;
		logic do1;
		logic do2;
	} sam_state_t;
endpackage

// File: spectral_alarm_monitor_test.sv
`timescale 1ns/1ps
module spectral_alarm_monitor_test;
	typedef struct packed {
		logic [2:0] pg;
		logic [15:0] diag, xs, ys, xp, yp;
		logic [7:0] xb, yb;
		logic d1, d2;
	} sam_hdr_t;
	logic CLK = 1'b0;
	logic SRST = 1'b1;
	logic BIN_VALID = 1'b0, BIN_AXIS = 1'b0, REC_DONE = 1'b0;
	logic [7:0] BIN_INDEX = 8'h00;
	logic [15:0] BIN_MAG = 16'h0000, SYS_TEMP = 16'h0000, SYS_SUPPLY = 16'h0000;
	logic [2:0] REC_PAGE = 3'h1;
	logic [47:0] BAND_LOW, BAND_HIGH;
	logic [5:0] PIN_FUNC = 6'h00;
	wire REG_WR, REG_RD, DIG_OUT1, DIG_OUT2, SAVE_STROBE, HDR_VALID;
	wire [2:0] REG_PAGE, SAVE_PAGE, HDR_PAGE;
	wire [7:0] REG_ADDR, REG_WDATA, HDR_XBIN, HDR_YBIN;
	wire [15:0] REG_RDATA, HDR_DIAG, HDR_XSTAT, HDR_YSTAT, HDR_XPEAK, HDR_YPEAK;
	int mismatches = 0;
	int tests_run = 0;
	sam_hdr_t hq[$];
	logic [15:0] rq[$];
	logic [2:0] sq[$];
	logic rd_pend = 1'b0;
	always #50 CLK = ~CLK;
	sam_host host (.CLK(CLK), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_PAGE(REG_PAGE),
		.REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA));
	sam_monitor dut (.CLK(CLK), .SRST(SRST), .REG_WR(REG_WR), .REG_RD(REG_RD),
		.REG_PAGE(REG_PAGE), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
		.REG_RDATA(REG_RDATA), .BIN_VALID(BIN_VALID), .BIN_AXIS(BIN_AXIS),
		.BIN_INDEX(BIN_INDEX), .BIN_MAG(BIN_MAG), .REC_DONE(REC_DONE), .REC_PAGE(REC_PAGE),
		.BAND_LOW(BAND_LOW), .BAND_HIGH(BAND_HIGH), .SYS_TEMP(SYS_TEMP),
		.SYS_SUPPLY(SYS_SUPPLY), .PIN_FUNC(PIN_FUNC), .DIG_OUT1(DIG_OUT1),
		.DIG_OUT2(DIG_OUT2), .SAVE_STROBE(SAVE_STROBE), .SAVE_PAGE(SAVE_PAGE),
		.HDR_VALID(HDR_VALID), .HDR_PAGE(HDR_PAGE), .HDR_DIAG(HDR_DIAG),
		.HDR_XSTAT(HDR_XSTAT), .HDR_YSTAT(HDR_YSTAT), .HDR_XPEAK(HDR_XPEAK),
		.HDR_YPEAK(HDR_YPEAK), .HDR_XBIN(HDR_XBIN), .HDR_YBIN(HDR_YBIN));
	// ----------
	// scoreboard
	// ----------
	task automatic chk(input logic [103:0] got, input logic [103:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// an unexpected save strobe is compared against page 0, which never matches
	always @(posedge CLK) begin
		if (rd_pend) chk(REG_RDATA, rq.pop_front());
		rd_pend <= REG_RD;
		if (HDR_VALID) chk({HDR_PAGE, HDR_DIAG, HDR_XSTAT, HDR_YSTAT,
			HDR_XPEAK, HDR_YPEAK, HDR_XBIN, HDR_YBIN, DIG_OUT1, DIG_OUT2}, hq.pop_front());
		if (SAVE_STROBE) chk(SAVE_PAGE, (sq.size() != 0) ? sq.pop_front() : 3'h0);
	end
	task automatic stop_test;
		if (mismatches == 0 && tests_run > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// ----------
	// stimulus
	// ----------
	task automatic rdx(input logic [2:0] pg, input logic [7:0] a, input logic [15:0] e);
		rq.push_back(e);
		host.rd(pg, a);
	endtask
	task automatic bin(input logic ax, input logic [7:0] idx, input logic [15:0] mag);
		@(posedge CLK);
		BIN_VALID <= 1'b1;
		BIN_AXIS <= ax;
		BIN_INDEX <= idx;
		BIN_MAG <= mag;
		@(posedge CLK);
		BIN_VALID <= 1'b0;
		BIN_MAG <= ~mag;
	endtask
	task automatic rec(input sam_hdr_t e);
		hq.push_back(e);
		@(posedge CLK);
		REC_DONE <= 1'b1;
		REC_PAGE <= e.pg;
		@(posedge CLK);
		REC_DONE <= 1'b0;
		repeat (2) @(posedge CLK);
	endtask
	initial begin
		repeat (5000) @(posedge CLK);
		mismatches++;
		$display("[ERR] %0t watchdog expired", $time);
		stop_test();
	end
	initial begin
		logic [15:0] w;
		logic [15:0] sc [4];
		sc = '{16'h0018, 16'h0038, 16'h0008, 16'h0008};
		for (int k = 0; k < 6; k++) begin
			BAND_LOW[8*k+:8] = 8'(20 * k);
			BAND_HIGH[8*k+:8] = 8'(20 * k + 10);
		end
		void'($urandom(9190));
		repeat (4) @(posedge CLK);
		SRST <= 1'b0;
		foreach (sc[i]) rdx(3'h6, 8'h24 + 8'(2 * i), 16'h0000);
		rdx(3'h1, 8'h30, 16'h0080);
		rdx(3'h1, 8'h50, 16'h0000);
		w = 16'($urandom) & 16'h7FFF;
		host.wr(3'h4, 8'h24, w);
		host.wr(3'h4, 8'h28, {1'b1, w[14:0]});
		rdx(3'h4, 8'h24, w);
		rdx(3'h4, 8'h28, {1'b1, w[14:0]});
		host.wr(3'h0, 8'h24, 16'hFFFF);
		rdx(3'h1, 8'h24, 16'h0000);
		rdx(3'h0, 8'h24, 16'h0000);
		host.wr(3'h1, 8'h38, 16'hFFFF);
		rdx(3'h1, 8'h38, 16'h0000);
		host.wr(3'h5, 8'h30, 16'hFFFF);
		rdx(3'h5, 8'h30, 16'h0FFB);
		host.save(3'h4);
		host.clr(3'h4);
		rdx(3'h4, 8'h28, 16'h0000);
		sq.push_back(3'h4);
		host.save(3'h4);
		host.wr(3'h4, 8'h26, 16'h0001);
		host.save(3'h4);
		PIN_FUNC <= 6'h01;
		host.wr(3'h1, 8'h30, 16'h0041);
		host.wr(3'h1, 8'h24, 16'h0050);
		host.wr(3'h1, 8'h28, 16'h0200);
		bin(1'b0, 8'd5, 16'h0100);
		bin(1'b0, 8'd15, 16'h0900);
		bin(1'b1, 8'd5, 16'hFFFF);
		rec({3'h1, 16'h0001, 16'h0011, 16'h0000, 16'h0100, 16'h0000, 8'h05, 8'h00,
			2'b10});
		bin(1'b0, 8'd25, 16'h0300);
		bin(1'b0, 8'd110, 16'h0060);
		rec({3'h1, 16'h0001, 16'h40C2, 16'h0000, 16'h0300, 16'h0000, 8'h19, 8'h00,
			2'b11});
		rdx(3'h1, 8'h3C, 16'h0300);
		rdx(3'h1, 8'h44, 16'h0019);
		PIN_FUNC <= 6'h00;
		bin(1'b0, 8'd5, 16'h0100);
		rec({3'h1, 16'h0001, 16'h0011, 16'h0000, 16'h0100, 16'h0000, 8'h05, 8'h00, 2'b00});
		host.wr(3'h2, 8'h30, 16'h0202);
		host.wr(3'h2, 8'h26, 16'h0010);
		host.wr(3'h2, 8'h2A, 16'h8000);
		REC_PAGE <= 3'h2;
		for (int i = 0; i < 3; i++) begin
			bin(1'b1, 8'd45, 16'h0020);
			rec({3'h2, (i == 2) ? 16'h0002 : 16'h0000, 16'h0000,
				(i == 2) ? 16'h0103 : 16'h0000, 16'h0000, (i == 2) ? 16'h0020 : 16'h0000,
				8'h00, (i == 2) ? 8'h2D : 8'h00, 2'b00});
		end
		host.wr(3'h3, 8'h2E, 16'h1000);
		foreach (sc[i]) begin
			host.wr(3'h3, 8'h30, sc[i]);
			SYS_TEMP <= (i == 1) ? 16'h0800 : 16'h2000;
			SYS_SUPPLY <= 16'($urandom_range(0, 4095)) + ((i == 3) ? 16'h1001 : 16'h0000);
			rec({3'h3, (i == 2) ? 16'h0000 : 16'h0004, 80'h0, 2'b00});
		end
		host.wr(3'h3, 8'h30, 16'h0098);
		SYS_TEMP <= 16'h2000;
		rec({3'h3, 16'h0004, 80'h0, 2'b00});
		SYS_TEMP <= 16'h0000;
		rec({3'h3, 16'h0004, 80'h0, 2'b00});
		host.wb(3'h3, 8'h36, 8'h10);
		rec({3'h3, 16'h0000, 80'h0, 2'b00});
		repeat (5) @(posedge CLK);
		if (rq.size() + hq.size() + sq.size() != 0) begin
			mismatches++;
			$display("[ERR] %0t expected results never appeared", $time);
		end
		stop_test();
	end
endmodule
